// [verif/msq_next_state_test.sv]
// Self-checking bench for the microsequencer next-state core.
// Assumes design files compiled first; programs the store over APB.
`timescale 1ns/1ps
`default_nettype none
module msq_next_state_test;
	logic        pclk;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, zero_flag, supervisor_mode, oe_n;
	logic [15:0] user_out;
	logic [7:0]  cond_in, cond_value = 8'h00;
	logic        mrst_n, busy, start = 1'b0;
	logic [3:0]  low_edges = 4'h6;
	logic [16:0] last = 17'h10000;
	logic [16:0] expq[$];
	logic [7:0]  conds[4] = '{8'h27, 8'h07, 8'h47, 8'h87};
	int          n_errors = 0;
	int          n_compared = 0;
	int          seq[$];

	msq_next_state u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cond_in(cond_in), .master_reset_low(mrst_n), .user_out(user_out),
		.user_out_oe_n(oe_n), .zero_flag(zero_flag),
		.supervisor_mode(supervisor_mode));
	msq_sys_model u_sys (.pclk(pclk), .start(start), .low_edges(low_edges),
		.cond_value(cond_value), .cond_in(cond_in),
		.master_reset_low(mrst_n), .busy(busy));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ------------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s seen %h want %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results

	// Each change of the outputs is one fetched word
	always @(posedge pclk) begin
		if ({oe_n, user_out} !== last) begin
			last = {oe_n, user_out};
			if (expq.size() > 0)
				check({15'h0, last}, {15'h0, expq.pop_front()}, "word");
		end
	end

	// ------------------------------------------------------------------
	// APB master and programming
	// ------------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin n_errors++; results(); end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	function automatic logic [35:0] mw(input logic [2:0] op,
		input logic [7:0] d, q, input logic [15:0] f, input logic e);
		return {e, op, d, q, f};
	endfunction : mw

	task automatic put(input logic [8:0] a, input logic [35:0] w);
		wr(msq_pkg::REG_UADDR, {23'h0, a});
		wr(msq_pkg::REG_UDATA_L, w[31:0]);
		wr(msq_pkg::REG_UDATA_H, {28'h0, w[35:32]});
	endtask : put

	task automatic pulse(input logic [3:0] n, input logic [7:0] c);
		int k;
		@(posedge pclk);
		start <= 1'b1; low_edges <= n; cond_value <= c;
		@(posedge pclk);
		start <= 1'b0;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (busy !== 1'b0 && k < 50);
		if (k >= 50) begin n_errors++; results(); end
	endtask : pulse

	// One pass: dispatch, call, counted loop, restore, multiway branch
	task automatic lap(input int i);
		int k;
		pulse(4'h6, conds[i]);
		seq = '{1, conds[i], 10, 11, 12, 11, 12, 11, 12, 11, 13, 14, 2, 3};
		foreach (seq[j])
			expq.push_back({seq[j] == 2, 16'(16'h1000 | seq[j])});
		expq.push_back({1'b0, 16'h2000 | i[15:0]});
		expq.push_back({1'b0, 16'h1000});
		for (k = 0; k < 300 && expq.size() > 0; k++) @(posedge pclk);
		if (expq.size() > 0) begin n_errors++; results(); end
		$display("test lap %0d done", i);
	endtask : lap

	initial begin
		logic [31:0] r;
		logic        e;
		void'($urandom(32'ha76397e9));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, msq_pkg::REG_STATUS, 32'h0, r, e);
		check(r, 32'h0010_0000, "status");
		apb(1'b0, 8'h1c, 32'h0, r, e);
		check({31'h0, e}, 32'h1, "unmapped");
		put(9'h000, mw(msq_pkg::OP_PUSHI, 8'h00, 8'h01, 16'h1000, 1'b1));
		put(9'h001, mw(msq_pkg::OP_RETURN, 8'h00, 8'h00, 16'h1001, 1'b1));
		foreach (conds[i])
			put({1'b0, conds[i]}, mw(msq_pkg::OP_CALL, 8'h02, 8'h0a,
				16'h1000 | conds[i], 1'b1));
		put(9'h00a, mw(msq_pkg::OP_PUSHLOADC, 8'h03, 8'h0b, 16'h100a, 1'b1));
		put(9'h00b, mw(msq_pkg::OP_LOOP_ON_NONZERO, 8'h0c, 8'h0d, 16'h100b, 1'b1));
		put(9'h00c, mw(msq_pkg::OP_JUMP, 8'h00, 8'h0b, 16'h100c, 1'b1));
		put(9'h00d, mw(msq_pkg::OP_POPC, 8'h00, 8'h0e, 16'h100d, 1'b1));
		put(9'h00e, mw(msq_pkg::OP_RETURN, 8'h00, 8'h00, 16'h100e, 1'b1));
		put(9'h004, mw(msq_pkg::OP_PUSHI, 8'h00, 8'h04, 16'h1004, 1'b1));
		put(9'h002, mw(msq_pkg::OP_CONTINUE, 8'h00, 8'h00, 16'h1002, 1'b0));
		put(9'h003, mw(msq_pkg::OP_JUMP, 8'h00, 8'hc9, 16'h1003, 1'b1));
		for (int i = 0; i < 4; i++)
			put(9'd228 + i[8:0], mw(msq_pkg::OP_RETURN, 8'h00, 8'h00,
				16'h2000 | i[15:0], 1'b1));
		// Location 9: terms 108..119, one live term per condition
		wr(msq_pkg::REG_PADDR, 32'd108);
		for (int j = 0; j < 12; j++)
			wr(msq_pkg::REG_PDATA, j == 0 ? 32'h2000 : j == 4 ? 32'h0040 :
				j == 8 ? 32'h0080 : 32'h0);
		wr(msq_pkg::REG_CTRL, 32'h1);
		for (int i = 0; i < 4; i++) lap(i);
		repeat (3) lap($urandom % 4);
		pulse(4'h1, 8'h00);
		repeat (2) @(posedge pclk);
		check({31'h0, supervisor_mode}, 32'h1, "supervisor");
		wr(msq_pkg::REG_CTRL, 32'h3);
		@(posedge pclk);
		check({31'h0, supervisor_mode}, 32'h0, "supervisor clear");
		$display("test supervisor done");
		// Self-looping push word fills the stack, then overwrites its top
		pulse(4'h6, 8'h04);
		repeat (30) @(posedge pclk);
		apb(1'b0, msq_pkg::REG_STATUS, 32'h0, r, e);
		check(r, 32'h001f_0004, "full stack");
		check({31'h0, zero_flag}, 32'h1, "zero flag");
		$display("test full stack done");
		results();
	end
endmodule : msq_next_state_test
`default_nettype wire

// [verif/msq_sys_model.sv]
// System-side model: drives the condition inputs and the master reset.
// Assumes the bench requests a reset pulse by a one-cycle start strobe.
`timescale 1ns/1ps
`default_nettype none
module msq_sys_model (
	// Clock and command
	input  wire logic       pclk,
	input  wire logic       start,
	input  wire logic [3:0] low_edges,
	input  wire logic [7:0] cond_value,
	// Pins toward the sequencer
	output logic      [7:0] cond_in,
	output logic            master_reset_low,
	output logic            busy
);
	logic [3:0] left = 4'h0;
	initial begin
		cond_in = 8'h00;
		master_reset_low = 1'b1;
		busy = 1'b0;
	end
	// Reset is held low for exactly low_edges rising edges, one when low_edges is 0
	always @(posedge pclk) begin
		if (start && !busy) begin
			cond_in          <= cond_value;
			master_reset_low <= 1'b0;
			left             <= low_edges;
			busy             <= 1'b1;
		end else if (busy) begin
			if (left > 4'h1) begin
				left <= left - 4'h1;
			end else begin
				master_reset_low <= 1'b1;
				busy             <= 1'b0;
			end
		end
	end
endmodule : msq_sys_model
`default_nettype wire

// [verilog/msq_branch_select.sv]
// Branch-select for one multiway location: three prioritized conditions.
// Each term: bits [7:0] select true inputs, [15:8] complemented inputs.
// A term with no literal selected is false.
`default_nettype none
`timescale 1ns/1ps

module msq_branch_select (
	// Programmed terms of the location, term 0 in the low bits
	input  wire logic [191:0] terms,
	// Condition inputs
	input  wire logic [7:0]   cond_in,
	// Selected word
	output logic      [1:0]   index
);
	logic [11:0] hit;
	logic [2:0]  cond;

	genvar t;
	generate
		for (t = 0; t < msq_pkg::TERMS_PER_LOC; t++) begin : g_term
			logic [15:0] tm;
			assign tm = terms[t*msq_pkg::PTERM_W +: msq_pkg::PTERM_W];
			assign hit[t] = (|tm) && ((tm[7:0] & ~cond_in) == 8'h00)
				&& ((tm[15:8] & cond_in) == 8'h00);
		end
		for (t = 0; t < 3; t++) begin : g_cond
			assign cond[t] = |hit[t*msq_pkg::TERMS_PER_CND +:
				msq_pkg::TERMS_PER_CND];
		end
	endgenerate

	// Highest condition wins regardless of the lower ones
	always_comb begin
		if (cond[2])
			index = 2'h3;
		else if (cond[1])
			index = 2'h2;
		else if (cond[0])
			index = 2'h1;
		else
			index = 2'h0;
	end

endmodule : msq_branch_select

`default_nettype wire

// [verilog/msq_next_state.sv]
// Next-state core of a microsequencer: microcode store, address mux,
// multiway branch select, stack, loop counter, master reset tracking.
// Assumes condition inputs and master_reset_low are synchronous to pclk;
// microcode and branch terms are loaded over APB before run is set.
//
// Design decisions made here: the APB register port and the register offsets.
`default_nettype none
`timescale 1ns/1ps

// What this block does
// - Next address comes from next-address field, constant, stack top or current address plus one.
// - Branch select acts only for next addresses of 192 and above.
// - Prioritized selection: condition three, two, one, else word zero.
// - Each condition is up to four product terms; 12 terms per location.
// - Fifteen-entry, 8-bit stack; top feeds address or counter.
// - Pushes take constant, counter, or the eight condition inputs.
// - Push and pop happen on the edge that loads the microword.
// - Popping an empty stack yields zero.
// - Push on full stack overwrites top only; depth stays.
// - Eight-bit down counter loads from constant or stack, saves to it.
// - Counter changes on the edge and never wraps below zero.
// - Zero flag is true whenever the counter is zero.
// - Output enable bit of the word drives or floats user outputs.
// - Valid master reset empties stack, clears counter, loads word zero.
// - One low edge enters supervisor mode; two edges undefined.
// - Word zero outputs from fourth low edge to third edge after release.
// - Continue goes to the following address, stack and counter kept.
// - Jump goes to the target address, stack and counter kept.
// - Call pushes the return target and goes to the subroutine.
// - Constant operands are 8-bit values used as address or count.
// - Fetched word is captured in the pipeline register on the edge.
// - Addresses 192 to 255 hold four words each; others hold one.
module msq_next_state (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// System side
	input  wire logic [7:0]  cond_in,
	input  wire logic        master_reset_low,
	output logic      [15:0] user_out,
	output logic             user_out_oe_n,
	output logic             zero_flag,
	output logic             supervisor_mode
);
	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [35:0] ucode [0:msq_pkg::UCODE_WORDS-1];
	logic [15:0] pterm [0:msq_pkg::PTERM_COUNT-1];

	logic [35:0]  pipe;
	logic [7:0]   cur_addr;
	logic [7:0]   loop_count_register;
	logic         run;
	logic [8:0]   uaddr;
	logic [31:0]  udata_lo;
	logic [9:0]   pt_addr;
	msq_pkg::msq_rst_type rst_state;

	// ------------------------------------------------------------------
	// Decode of the current word
	// ------------------------------------------------------------------
	msq_pkg::msq_op_type op;
	logic [7:0] q_field;
	logic [7:0] d_field;
	assign op      = msq_pkg::msq_op_type'(pipe[msq_pkg::OP_MSB:msq_pkg::OP_LSB]);
	assign q_field = pipe[msq_pkg::Q_MSB:msq_pkg::Q_LSB];
	assign d_field = pipe[msq_pkg::D_MSB:msq_pkg::D_LSB];

	logic [7:0] stack_top;
	logic [3:0] stack_depth;
	logic       advance;
	assign advance = run && master_reset_low
		&& (rst_state == msq_pkg::RS_RUN || rst_state == msq_pkg::RS_HOLD2);

	// ------------------------------------------------------------------
	// Address multiplexer and stack/counter requests
	// ------------------------------------------------------------------
	logic [7:0] next_addr;
	logic       do_push;
	logic       do_pop;
	logic [7:0] push_val;
	logic       cnt_load;
	logic       cnt_dec;
	logic [7:0] cnt_val;

	always_comb begin
		next_addr = q_field;
		do_push   = 1'b0;
		do_pop    = 1'b0;
		push_val  = d_field;
		cnt_load  = 1'b0;
		cnt_dec   = 1'b0;
		cnt_val   = d_field;
		case (op)
			msq_pkg::OP_CONTINUE: next_addr = cur_addr + msq_pkg::ADDR_STEP;
			msq_pkg::OP_JUMP: next_addr = q_field;
			msq_pkg::OP_CALL: begin
				do_push = 1'b1;
			end
			msq_pkg::OP_RETURN: begin
				next_addr = stack_top;
				do_pop    = 1'b1;
			end
			msq_pkg::OP_LOOP_ON_NONZERO: begin
				next_addr = zero_flag ? q_field : d_field;
				cnt_dec   = 1'b1;
			end
			msq_pkg::OP_PUSHLOADC: begin
				do_push  = 1'b1;
				push_val = loop_count_register;
				cnt_load = 1'b1;
			end
			msq_pkg::OP_POPC: begin
				do_pop   = 1'b1;
				cnt_load = 1'b1;
				cnt_val  = stack_top;
			end
			msq_pkg::OP_PUSHI: begin
				do_push  = 1'b1;
				push_val = cond_in;
			end
			default: next_addr = q_field;
		endcase
	end

	// ------------------------------------------------------------------
	// Multiway branch select
	// ------------------------------------------------------------------
	logic         multi;
	logic [191:0] loc_terms;
	logic [1:0]   branch_idx;
	logic [8:0]   fetch_addr;

	assign multi = next_addr >= msq_pkg::MULTI_BASE;

	always_comb begin
		loc_terms = '0;
		for (int i = 0; i < msq_pkg::TERMS_PER_LOC; i++)
			loc_terms[i*msq_pkg::PTERM_W +: msq_pkg::PTERM_W] =
				pterm[10'(next_addr[5:0] * msq_pkg::TERMS_PER_LOC + i)];
	end

	msq_branch_select u_branch (
		.terms   (loc_terms),
		.cond_in (cond_in),
		.index   (branch_idx)
	);

	// Below 192 the select is off; above, four words per address
	assign fetch_addr = multi
		? msq_pkg::MULTI_BASE_9 + {1'b0, next_addr[5:0], branch_idx}
		: {1'b0, next_addr};

	// ------------------------------------------------------------------
	// Stack
	// ------------------------------------------------------------------
	logic stack_clear;
	assign stack_clear = !master_reset_low
		&& (rst_state == msq_pkg::RS_LOW2 || rst_state == msq_pkg::RS_LOWX);

	msq_stack u_stack (
		.pclk      (pclk),
		.presetn   (presetn),
		.clear     (stack_clear),
		.push      (advance && do_push),
		.pop       (advance && do_pop),
		.push_data (push_val),
		.top       (stack_top),
		.depth     (stack_depth)
	);

	// ------------------------------------------------------------------
	// Loop counter and zero flag
	// ------------------------------------------------------------------
	logic [7:0] next_count;
	always_comb begin
		next_count = loop_count_register;
		if (stack_clear)
			next_count = msq_pkg::COUNT_ZERO;
		else if (advance && cnt_load)
			next_count = cnt_val;
		else if (advance && cnt_dec && !zero_flag)
			next_count = loop_count_register - 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_count_register <= msq_pkg::COUNT_ZERO;
			zero_flag           <= 1'b1;
		end else begin
			loop_count_register <= next_count;
			zero_flag           <= next_count == msq_pkg::COUNT_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// Pipeline register and outputs
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pipe          <= '0;
			cur_addr      <= 8'h00;
			user_out      <= 16'h0000;
			user_out_oe_n <= 1'b1;
		end else if (!master_reset_low && rst_state == msq_pkg::RS_LOWX) begin
			pipe          <= ucode[0];
			cur_addr      <= 8'h00;
			user_out      <= ucode[0][msq_pkg::F_MSB:msq_pkg::F_LSB];
			user_out_oe_n <= !ucode[0][msq_pkg::E_BIT];
		end else if (advance) begin
			pipe          <= ucode[fetch_addr];
			cur_addr      <= next_addr;
			user_out      <= ucode[fetch_addr][msq_pkg::F_MSB:msq_pkg::F_LSB];
			user_out_oe_n <= !ucode[fetch_addr][msq_pkg::E_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Master reset tracking
	// ------------------------------------------------------------------
	// Two low edges are undefined; here they simply resume running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rst_state <= msq_pkg::RS_RUN;
		else if (!master_reset_low) begin
			case (rst_state)
				msq_pkg::RS_LOW1: rst_state <= msq_pkg::RS_LOW2;
				msq_pkg::RS_LOW2: rst_state <= msq_pkg::RS_LOWX;
				msq_pkg::RS_LOWX: rst_state <= msq_pkg::RS_LOWX;
				default:          rst_state <= msq_pkg::RS_LOW1;
			endcase
		end else begin
			case (rst_state)
				msq_pkg::RS_LOW1:  rst_state <= msq_pkg::RS_SUPER;
				msq_pkg::RS_LOW2:  rst_state <= msq_pkg::RS_RUN;
				msq_pkg::RS_LOWX:  rst_state <= msq_pkg::RS_HOLD1;
				msq_pkg::RS_HOLD1: rst_state <= msq_pkg::RS_HOLD2;
				msq_pkg::RS_HOLD2: rst_state <= msq_pkg::RS_RUN;
				msq_pkg::RS_SUPER: rst_state <= msq_pkg::RS_SUPER;
				default:           rst_state <= msq_pkg::RS_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	logic apb_setup;
	logic apb_wr;
	logic mapped;
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pready && pwrite;
	assign mapped    = paddr <= msq_pkg::REG_PDATA && paddr[1:0] == 2'b00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !mapped;
			prdata  <= 32'h0000_0000;
			if (apb_setup && !pwrite) begin
				case (paddr)
					msq_pkg::REG_CTRL:    prdata <= {31'h0, run};
					msq_pkg::REG_STATUS:  prdata <= {9'h0, rst_state != msq_pkg::RS_RUN,
						supervisor_mode, zero_flag, stack_depth,
						loop_count_register, cur_addr};
					msq_pkg::REG_UADDR:   prdata <= {23'h0, uaddr};
					msq_pkg::REG_UDATA_L: prdata <= udata_lo;
					msq_pkg::REG_PADDR:   prdata <= {22'h0, pt_addr};
					default:              prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run      <= 1'b0;
			uaddr    <= 9'h000;
			udata_lo <= 32'h0000_0000;
			pt_addr  <= 10'h000;
		end else if (apb_wr) begin
			case (paddr)
				msq_pkg::REG_CTRL:    run      <= pwdata[msq_pkg::CTRL_RUN];
				msq_pkg::REG_UADDR:   uaddr    <= pwdata[8:0];
				msq_pkg::REG_UDATA_L: udata_lo <= pwdata;
				msq_pkg::REG_UDATA_H: uaddr    <= uaddr + 9'h001;
				msq_pkg::REG_PADDR:   pt_addr  <= pwdata[9:0];
				msq_pkg::REG_PDATA:   pt_addr  <= pt_addr + 10'h001;
				default:              run      <= run;
			endcase
		end
	end

	// Store writes; an index past the end is dropped
	always_ff @(posedge pclk) begin
		if (apb_wr && paddr == msq_pkg::REG_UDATA_H
			&& uaddr < 9'(msq_pkg::UCODE_WORDS))
			ucode[uaddr] <= {pwdata[3:0], udata_lo};
		if (apb_wr && paddr == msq_pkg::REG_PDATA
			&& pt_addr < 10'(msq_pkg::PTERM_COUNT))
			pterm[pt_addr] <= pwdata[15:0];
	end

	// Supervisor entry wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			supervisor_mode <= 1'b0;
		else if (master_reset_low && rst_state == msq_pkg::RS_LOW1)
			supervisor_mode <= 1'b1;
		else if (apb_wr && paddr == msq_pkg::REG_CTRL && pwdata[msq_pkg::CTRL_SVCLR])
			supervisor_mode <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	count_nowrap_a: assert property (
		advance && op == msq_pkg::OP_LOOP_ON_NONZERO && zero_flag
		|=> loop_count_register == 8'h00 && zero_flag)
		else $error("counter left zero on loop");
	loop_dec_a: assert property (
		advance && op == msq_pkg::OP_LOOP_ON_NONZERO && !zero_flag
		|=> cur_addr == $past(d_field)
		&& loop_count_register == $past(loop_count_register) - 8'h01)
		else $error("loop on nonzero took wrong path");
	continue_step_a: assert property (
		advance && op == msq_pkg::OP_CONTINUE
		|=> cur_addr == 8'($past(cur_addr) + 8'h01) && $stable(stack_depth))
		else $error("continue did not step address");
	jump_target_a: assert property (
		advance && op == msq_pkg::OP_JUMP
		|=> cur_addr == $past(q_field) && $stable(loop_count_register))
		else $error("jump target wrong");
	call_push_a: assert property (
		advance && op == msq_pkg::OP_CALL && stack_depth < 4'hf
		|=> stack_depth == $past(stack_depth) + 4'h1
		&& stack_top == $past(d_field) && cur_addr == $past(q_field))
		else $error("call did not push return");
	empty_zero_a: assert property (
		stack_depth == 4'h0 |-> stack_top == 8'h00)
		else $error("empty stack top not zero");
	full_push_a: assert property (
		advance && do_push && stack_depth == 4'hf
		|=> stack_depth == 4'hf && stack_top == $past(push_val))
		else $error("full push changed depth");
	reset_load_a: assert property (
		!master_reset_low && rst_state == msq_pkg::RS_LOWX
		|=> cur_addr == 8'h00 && loop_count_register == 8'h00
		&& stack_depth == 4'h0)
		else $error("master reset incomplete");
	release_hold_a: assert property (
		master_reset_low && rst_state == msq_pkg::RS_LOWX
		|=> $stable(user_out) [*2])
		else $error("startup outputs not held");
	supervisor_entry_a: assert property (
		master_reset_low && rst_state == msq_pkg::RS_LOW1
		|=> supervisor_mode)
		else $error("supervisor mode not entered");

	multiway_c: cover property (advance && multi && branch_idx == 2'h3);
	loop_exit_c: cover property (advance && op == msq_pkg::OP_LOOP_ON_NONZERO && zero_flag);
	full_reset_c: cover property (rst_state == msq_pkg::RS_HOLD2 && advance);

endmodule : msq_next_state

`default_nettype wire

// [verilog/msq_pkg.sv]
// Package for the microsequencer next-state core.
// Holds microword layout, opcodes, register map, reset-tracking states.
// Assumes a single clock; no module is defined here.
`default_nettype none

package msq_pkg;

	// ------------------------------------------------------------------
	// Microword layout
	// ------------------------------------------------------------------
	localparam int WORD_W      = 36;
	localparam int F_LSB       = 0;
	localparam int F_MSB       = 15;
	localparam int Q_LSB       = 16;
	localparam int Q_MSB       = 23;
	localparam int D_LSB       = 24;
	localparam int D_MSB       = 31;
	localparam int OP_LSB      = 32;
	localparam int OP_MSB      = 34;
	localparam int E_BIT       = 35;
	localparam int UCODE_WORDS = 448;
	localparam int UADDR_W     = 9;

	// ------------------------------------------------------------------
	// Multiway region and branch-select array
	// ------------------------------------------------------------------
	localparam logic [7:0] MULTI_BASE   = 8'hc0;
	localparam logic [8:0] MULTI_BASE_9 = 9'h0c0;
	localparam int         TERMS_PER_LOC = 12;
	localparam int         TERMS_PER_CND = 4;
	localparam int         MULTI_LOCS    = 64;
	localparam int         PTERM_COUNT   = 768;
	localparam int         PTERM_W       = 16;
	localparam int         PADDR_W       = 10;

	// ------------------------------------------------------------------
	// Stack and counter
	// ------------------------------------------------------------------
	localparam int         STACK_DEPTH = 15;
	localparam int         DATA_W      = 8;
	localparam logic [3:0] STACK_FULL  = 4'hf;
	localparam logic [7:0] COUNT_ZERO  = 8'h00;
	localparam logic [7:0] ADDR_STEP   = 8'h01;

	typedef enum logic [2:0] {
		OP_CONTINUE  = 3'h0,
		OP_JUMP      = 3'h1,
		OP_CALL      = 3'h2,
		OP_RETURN    = 3'h3,
		OP_LOOP_ON_NONZERO    = 3'h4,
		OP_PUSHLOADC = 3'h5,
		OP_POPC      = 3'h6,
		OP_PUSHI     = 3'h7
	} msq_op_type;

	// Master reset tracking
	typedef enum logic [2:0] {
		RS_RUN   = 3'h0,
		RS_LOW1  = 3'h1,
		RS_LOW2  = 3'h2,
		RS_LOWX  = 3'h3,
		RS_HOLD1 = 3'h4,
		RS_HOLD2 = 3'h5,
		RS_SUPER = 3'h6
	} msq_rst_type;

	// ------------------------------------------------------------------
	// APB register map (byte addresses)
	// ------------------------------------------------------------------
	localparam int         PADDR_BUS_W = 8;
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_UADDR   = 8'h08;
	localparam logic [7:0] REG_UDATA_L = 8'h0c;
	localparam logic [7:0] REG_UDATA_H = 8'h10;
	localparam logic [7:0] REG_PADDR   = 8'h14;
	localparam logic [7:0] REG_PDATA   = 8'h18;
	localparam int         CTRL_RUN    = 0;
	localparam int         CTRL_SVCLR  = 1;

endpackage : msq_pkg

`default_nettype wire

// [verilog/msq_stack.sv]
// LIFO stack, 15 words of 8 bits, top reads zero when empty.
// Assumes push and pop are never requested together.
`default_nettype none
`timescale 1ns/1ps

module msq_stack (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control
	input  wire logic       clear,
	input  wire logic       push,
	input  wire logic       pop,
	input  wire logic [7:0] push_data,
	// State
	output logic      [7:0] top,
	output logic      [3:0] depth
);
	logic [7:0] mem [0:msq_pkg::STACK_DEPTH-1];
	logic [3:0] next_depth;

	// Reading an empty stack yields zero
	assign top = (depth == 4'h0) ? msq_pkg::COUNT_ZERO
		: mem[depth - 4'h1];

	always_comb begin
		next_depth = depth;
		if (clear)
			next_depth = 4'h0;
		else if (push && depth != msq_pkg::STACK_FULL)
			next_depth = depth + 4'h1;
		else if (pop && depth != 4'h0)
			next_depth = depth - 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			depth <= 4'h0;
		else
			depth <= next_depth;
	end

	// Full stack: push lands on the top slot, others untouched
	always_ff @(posedge pclk) begin
		if (push && !clear) begin
			if (depth == msq_pkg::STACK_FULL)
				mem[depth - 4'h1] <= push_data;
			else
				mem[depth] <= push_data;
		end
	end

endmodule : msq_stack

`default_nettype wire
